// *** design/earth_fault_trip_logic.sv ***
// Three residual levels, breaker failure supervision and remote trip.
// Assumes all inputs are synchronous to core_clk; inverse curve time is
// computed outside and presented on curve_delay in 10 ms ticks.
`timescale 1ns/1ps
module earth_fault_trip_logic #(
    parameter int TICK_CYCLES = ef_trip_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Measurements
    input wire logic [ef_trip_pkg::CUR_W-1:0] io_mag,
    input wire logic [ef_trip_pkg::PH_W-1:0] ph_mag_a,
    input wire logic [ef_trip_pkg::PH_W-1:0] ph_mag_b,
    input wire logic [ef_trip_pkg::PH_W-1:0] ph_mag_c,
    // Digital inputs
    input wire logic block_input,
    input wire logic remote_trip_input,
    input wire logic reset_button,
    // Residual level settings, bit i is level i+1
    input wire logic [2:0] function_enable_setting,
    input wire logic [2:0] block_input_option,
    input wire logic [2:0] osc_trigger_option,
    input wire ef_trip_pkg::curve_e delay_curve_select,
    input wire logic [ef_trip_pkg::DLY_W-1:0] curve_delay,
    input wire logic [ef_trip_pkg::THR_W-1:0] first_residual_threshold,
    input wire logic [ef_trip_pkg::THR_W-1:0] second_residual_threshold,
    input wire logic [ef_trip_pkg::THR_W-1:0] third_residual_threshold,
    input wire logic [ef_trip_pkg::DLY_W-1:0] first_residual_delay,
    input wire logic [ef_trip_pkg::DLY_W-1:0] second_residual_delay,
    input wire logic [ef_trip_pkg::DLY_W-1:0] third_residual_delay,
    // Breaker failure and remote trip settings
    input wire logic breaker_failure_function,
    input wire logic [1:0] supervised_trip_relay,
    input wire logic [ef_trip_pkg::BFD_W-1:0] breaker_failure_delay,
    input wire logic remote_trip_function,
    // Outputs
    output logic [3:0] relay_out,
    output logic trip_led,
    output logic osc_trigger,
    output logic [2:0] last_trip,
    output logic [2:0] level_pickup
);
    typedef struct packed {
        logic [ef_trip_pkg::PRE_W-1:0] pre;
        logic tick;
        logic [2:0] pick;
        logic [2:0] trip;
        logic [2:0][ef_trip_pkg::DLY_W-1:0] cnt;
        logic rtrip;
        logic [ef_trip_pkg::BFD_W-1:0] bfcnt;
        logic bf;
        logic [3:0] relay;
        logic led;
        logic osc;
        logic [2:0] last;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic [2:0][ef_trip_pkg::THR_W-1:0] thr;
    logic [2:0][ef_trip_pkg::DLY_W-1:0] dly;
    logic [2:0] over;
    logic [2:0] under;
    logic [2:0] rise;
    logic [ef_trip_pkg::PH_W-1:0] ph_max;
    logic [1:0] bf_relay;

    assign thr[0] = first_residual_threshold;
    assign thr[1] = second_residual_threshold;
    assign thr[2] = third_residual_threshold;
    // Inverse shapes use the externally computed curve time
    assign dly[0] = (delay_curve_select == ef_trip_pkg::CURVE_DT) ?
        first_residual_delay : curve_delay;
    assign dly[1] = second_residual_delay;
    assign dly[2] = third_residual_delay;
    assign bf_relay = supervised_trip_relay + 2'h1;

    // Release at 95 percent compared by cross multiplication, no divider
    genvar g;
    generate
        for (g = 0; g < ef_trip_pkg::NLEV; g++) begin : g_cmp
            assign over[g] = {1'b0, io_mag} > {2'h0, thr[g]};
            assign under[g] = (ef_trip_pkg::PROD_W'(io_mag) *
                ef_trip_pkg::PROD_W'(ef_trip_pkg::FULL_PCT)) <
                (ef_trip_pkg::PROD_W'(thr[g]) *
                ef_trip_pkg::PROD_W'(ef_trip_pkg::RESET_PCT));
        end
    endgenerate

    always_comb begin
        ph_max = ph_mag_a;
        if (ph_mag_b > ph_max) begin
            ph_max = ph_mag_b;
        end
        if (ph_mag_c > ph_max) begin
            ph_max = ph_mag_c;
        end
    end

    always_comb begin
        st_nxt = st_r;
        // 10 ms time base; parameter shortens it in simulation
        st_nxt.tick = 1'b0;
        if (st_r.pre >= ef_trip_pkg::PRE_W'(TICK_CYCLES - 1)) begin
            st_nxt.pre = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.pre = st_r.pre + 1'b1;
        end
        for (int i = 0; i < ef_trip_pkg::NLEV; i++) begin
            if (!function_enable_setting[i]) begin
                st_nxt.pick[i] = 1'b0;
                st_nxt.trip[i] = 1'b0;
                st_nxt.cnt[i] = '0;
            end else begin
                st_nxt.pick[i] = over[i] | (st_r.pick[i] & ~under[i]);
                if (!st_nxt.pick[i]) begin
                    st_nxt.cnt[i] = '0;
                    st_nxt.trip[i] = 1'b0;
                end else begin
                    if (st_r.tick && st_r.cnt[i] < dly[i]) begin
                        st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
                    end
                    st_nxt.trip[i] = st_r.trip[i] |
                        ((st_r.cnt[i] >= dly[i]) &
                        ~(block_input_option[i] & block_input));
                end
            end
        end
        st_nxt.rtrip = remote_trip_function & remote_trip_input;
        // Failure timer runs only while the supervised relay is closed
        if (!breaker_failure_function ||
            !st_r.relay[supervised_trip_relay]) begin
            st_nxt.bfcnt = '0;
            st_nxt.bf = 1'b0;
        end else begin
            if (st_r.tick && st_r.bfcnt < breaker_failure_delay) begin
                st_nxt.bfcnt = st_r.bfcnt + 1'b1;
            end
            st_nxt.bf = (st_r.bfcnt >= breaker_failure_delay) &&
                (ph_max > ef_trip_pkg::BF_LEVEL);
        end
        st_nxt.relay = '0;
        st_nxt.relay[supervised_trip_relay] = |st_nxt.trip |
            st_nxt.rtrip;
        st_nxt.relay[bf_relay] = st_nxt.bf;
        rise = st_nxt.trip & ~st_r.trip;
        st_nxt.osc = |(rise & osc_trigger_option);
        // A new trip wins over a push-button press in the same cycle
        st_nxt.led = (|rise) | (st_nxt.rtrip & ~st_r.rtrip) |
            (st_r.led & ~reset_button);
        if (st_nxt.bf && !st_r.bf) begin
            st_nxt.last = ef_trip_pkg::LAST_BF;
        end
        if (st_nxt.rtrip && !st_r.rtrip) begin
            st_nxt.last = ef_trip_pkg::LAST_REMOTE;
        end
        for (int i = ef_trip_pkg::NLEV - 1; i >= 0; i--) begin
            if (rise[i]) begin
                st_nxt.last = 3'(i + 1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign relay_out = st_r.relay;
    assign trip_led = st_r.led;
    assign osc_trigger = st_r.osc;
    assign last_trip = st_r.last;
    assign level_pickup = st_r.pick;

    sequence s_lvl0_rise;
        !st_r.trip[0] ##1 st_r.trip[0];
    endsequence

    sequence s_remote_rise;
        !st_r.rtrip ##1 st_r.rtrip;
    endsequence

    sequence s_lvl1_rise;
        !st_r.trip[1] ##1 st_r.trip[1];
    endsequence

    sequence s_lvl2_rise;
        !st_r.trip[2] ##1 st_r.trip[2];
    endsequence

    a_led_on_trip: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_lvl0_rise |-> trip_led)
        else $error("lamp not lit on level one trip");
    a_led_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
        trip_led && !reset_button |=> trip_led)
        else $error("lamp dropped without push-button");
    a_led_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
        reset_button && st_nxt.trip == st_r.trip && st_nxt.rtrip == st_r.rtrip
        |=> !trip_led)
        else $error("lamp not cleared by push-button");
    a_record_level: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_lvl0_rise |-> last_trip == 3'h1)
        else $error("level one trip not recorded");
    a_remote_record: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        s_remote_rise ##0 (st_r.trip == $past(st_r.trip))
        |-> last_trip == ef_trip_pkg::LAST_REMOTE)
        else $error("remote trip not recorded");
    a_disabled_quiet: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !function_enable_setting[1] |=> !st_r.pick[1] && !st_r.trip[1])
        else $error("disabled level acted");
    a_remote_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
        !remote_trip_function |=> !st_r.rtrip)
        else $error("remote trip while disabled");
    a_release_95: assert property (@(posedge core_clk) disable iff (!arst_n)
        function_enable_setting[2] && under[2] |=> !st_r.pick[2])
        else $error("level three held below reset level");
    a_block_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
        block_input_option[0] && block_input && !st_r.trip[0]
        |=> !st_r.trip[0])
        else $error("blocked level one tripped");
    a_trip_on_time: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        $rose(st_r.trip[0]) |-> $past(st_r.cnt[0]) >= $past(dly[0]))
        else $error("level one tripped early");
    a_bf_late: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(st_r.bf) |-> $past(st_r.bfcnt) >= $past(breaker_failure_delay)
        && relay_out[bf_relay])
        else $error("breaker failure early or relay missing");
    a_osc_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
        osc_trigger |-> $past(osc_trigger_option) != 3'h0)
        else $error("recorder trigger without option");
    a_lvl2_led: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        s_lvl1_rise |-> trip_led)
        else $error("lamp not lit on level two trip");
    a_lvl3_led: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        s_lvl2_rise |-> trip_led)
        else $error("lamp not lit on level three trip");
    a_lvl2_record: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        s_lvl1_rise ##0 !$rose(st_r.trip[0]) |-> last_trip == 3'h2)
        else $error("level two trip not recorded");
    a_lvl3_record: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        s_lvl2_rise ##0 (!$rose(st_r.trip[0]) && !$rose(st_r.trip[1]))
        |-> last_trip == 3'h3)
        else $error("level three trip not recorded");
    a_lvl2_time: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        $rose(st_r.trip[1]) |-> $past(st_r.cnt[1]) >= $past(dly[1]))
        else $error("level two tripped early");
    a_lvl3_time: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        $rose(st_r.trip[2]) |-> $past(st_r.cnt[2]) >= $past(dly[2]))
        else $error("level three tripped early");
    a_release_lvl1: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        function_enable_setting[0] && under[0] |=> !st_r.pick[0])
        else $error("level one held below reset level");
    a_release_lvl2: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        function_enable_setting[1] && under[1] |=> !st_r.pick[1])
        else $error("level two held below reset level");
    a_pickup_over: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        function_enable_setting[0] && over[0] |=> st_r.pick[0])
        else $error("level one missed pickup");
    a_relay_trip: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (|st_r.trip) && $stable(supervised_trip_relay)
        |-> relay_out[supervised_trip_relay])
        else $error("trip relay not closed on trip");
    a_remote_relay: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        st_r.rtrip && $stable(supervised_trip_relay)
        |-> relay_out[supervised_trip_relay])
        else $error("trip relay not closed on remote trip");
    a_bf_disabled: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !breaker_failure_function |=> !st_r.bf)
        else $error("breaker failure while disabled");
    a_bf_current: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        $rose(st_r.bf) |-> $past(ph_max) > ef_trip_pkg::BF_LEVEL)
        else $error("breaker failure without line current");
    a_osc_pulse: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        osc_trigger |=> !osc_trigger)
        else $error("recorder trigger longer than one cycle");
    a_osc_cause: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        osc_trigger |-> st_r.trip != $past(st_r.trip))
        else $error("recorder trigger without a new trip");
    a_cnt_restart: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !st_r.pick[0] |-> st_r.cnt[0] == '0)
        else $error("level one timer kept without pickup");
    a_disabled_lvl1: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !function_enable_setting[0] |=> !st_r.pick[0] && !st_r.trip[0])
        else $error("disabled level one acted");
    a_block_lvl2: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        block_input_option[1] && block_input && !st_r.trip[1]
        |=> !st_r.trip[1])
        else $error("blocked level two tripped");
endmodule : earth_fault_trip_logic

// *** design/ef_trip_pkg.sv ***
// Constants and types for the residual earth fault trip logic.
// Assumes currents arrive as magnitudes in hundredths of rated current.
package ef_trip_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PRE_W = 22;
    localparam int CUR_W = 11;
    localparam int PH_W = 13;
    localparam int THR_W = 10;
    localparam int DLY_W = 13;
    localparam int BFD_W = 7;
    localparam int PROD_W = 18;
    localparam int NLEV = 3;
    localparam logic [6:0] RESET_PCT = 7'h5F;
    localparam logic [6:0] FULL_PCT = 7'h64;
    localparam logic [PH_W-1:0] BF_LEVEL = 13'h0005;
    localparam logic [2:0] LAST_NONE = 3'h0;
    localparam logic [2:0] LAST_REMOTE = 3'h4;
    localparam logic [2:0] LAST_BF = 3'h5;
    typedef enum logic [3:0] {
        CURVE_DT, IEC_A, IEC_B, IEC_C, IEEE_MI, IEEE_VI, IEEE_I, IEEE_EI,
        IEEE_SI
    } curve_e;
endpackage : ef_trip_pkg

// *** dv/breaker_model.sv ***
// Circuit breaker and phase current source for the trip logic bench.
// Assumes the trip command is a registered level on core_clk.
`timescale 1ns/1ps
module breaker_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Trip coil and fault options
    input wire logic trip_cmd,
    input wire logic stuck,
    input wire logic [12:0] load,
    // Phase currents
    output logic [12:0] ph_a,
    output logic [12:0] ph_b,
    output logic [12:0] ph_c
);
    // Contacts part a few cycles after the coil is energised
    logic [1:0] open_cnt_r;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) open_cnt_r <= 2'h0;
        else if (!trip_cmd || stuck) open_cnt_r <= 2'h0;
        else if (open_cnt_r != 2'h3) open_cnt_r <= open_cnt_r + 2'h1;
    end
    // Uneven phases so the maximum is not always phase a
    assign ph_a = (open_cnt_r == 2'h3) ? 13'h0000 : load >> 1;
    assign ph_b = (open_cnt_r == 2'h3) ? 13'h0000 : load;
    assign ph_c = ph_a >> 1;
endmodule : breaker_model

// *** dv/tb_earth_fault_trip_logic.sv ***
// Self-checking bench for the residual earth fault trip logic.
// Assumes a 4-cycle tick and relay 3 as the supervised trip relay.
`timescale 1ns/1ps
module tb_earth_fault_trip_logic;
    localparam int TC = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [10:0] io_mag = 11'h000;
    logic [12:0] ph_mag_a, ph_mag_b, ph_mag_c;
    logic block_input = 1'b0;
    logic remote_trip_input = 1'b0;
    logic reset_button = 1'b0;
    logic [2:0] function_enable_setting = 3'h0;
    logic [2:0] block_input_option = 3'h0;
    logic [2:0] osc_trigger_option = 3'h1;
    ef_trip_pkg::curve_e delay_curve_select = ef_trip_pkg::CURVE_DT;
    logic [12:0] curve_delay = 13'h0005;
    logic [9:0] first_residual_threshold = 10'h00A;
    logic [9:0] second_residual_threshold = 10'h032;
    logic [9:0] third_residual_threshold = 10'h0C8;
    logic [12:0] first_residual_delay = 13'h0005;
    logic [12:0] second_residual_delay = 13'h0005;
    logic [12:0] third_residual_delay = 13'h0006;
    logic breaker_failure_function = 1'b0;
    logic [1:0] supervised_trip_relay = 2'h3;
    logic [6:0] breaker_failure_delay = 7'h05;
    logic remote_trip_function = 1'b0;
    logic [3:0] relay_out;
    logic trip_led, osc_trigger;
    logic [2:0] last_trip, level_pickup;
    logic stuck = 1'b0;
    logic [12:0] load = 13'h0064;
    int n_errors = 0;
    int samples_checked = 0;
    int n;

    always #2 core_clk = ~core_clk;

    earth_fault_trip_logic #(.TICK_CYCLES(TC)) DUT (.core_clk, .arst_n,
        .io_mag, .ph_mag_a, .ph_mag_b, .ph_mag_c, .block_input,
        .remote_trip_input, .reset_button, .function_enable_setting,
        .block_input_option, .osc_trigger_option, .delay_curve_select,
        .curve_delay, .first_residual_threshold, .second_residual_threshold,
        .third_residual_threshold, .first_residual_delay,
        .second_residual_delay, .third_residual_delay,
        .breaker_failure_function, .supervised_trip_relay,
        .breaker_failure_delay, .remote_trip_function, .relay_out,
        .trip_led, .osc_trigger, .last_trip, .level_pickup);

    breaker_model bkr (.core_clk, .arst_n, .trip_cmd(relay_out[3]), .stuck,
        .load, .ph_a(ph_mag_a), .ph_b(ph_mag_b), .ph_c(ph_mag_c));

    task automatic test_done;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc

    // Bounded wait for one relay; running out ends the run
    task automatic wt(input int b, input int lim, output int m);
        m = 0;
        while (relay_out[b] !== 1'b1 && m < lim) begin
            cyc(1);
            m++;
        end
        if (m >= lim) begin
            n_errors++;
            test_done();
        end
    endtask : wt

    // Trip time in ticks may slip by one prescaler phase
    task automatic fire(input int d, input logic [2:0] code);
        wt(3, 400, n);
        check(8'(n >= (d - 1) * TC && n <= d * TC + TC + 3), 8'h01);
        check(8'({trip_led, last_trip}), {4'h0, 1'b1, code});
    endtask : fire

    task automatic clr;
        io_mag = 11'h000;
        function_enable_setting = 3'h0;
        block_input = 1'b0;
        remote_trip_input = 1'b0;
        cyc(3);
        reset_button = 1'b1;
        cyc(1);
        reset_button = 1'b0;
        cyc(1);
    endtask : clr

    initial begin
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        cyc(2);
        function_enable_setting = 3'h1;
        io_mag = 11'h00B;
        cyc(12);
        io_mag = 11'h000;
        cyc(2);
        io_mag = 11'h00B;
        fire(5, 3'h1);
        check(8'(osc_trigger), 8'h01);
        cyc(1);
        check(8'(osc_trigger), 8'h00);
        io_mag = 11'h00A;
        cyc(3);
        check(8'(level_pickup), 8'h01);
        io_mag = 11'h009;
        cyc(2);
        check(8'({trip_led, level_pickup, relay_out}), 8'h80);
        clr();
        check(8'(trip_led), 8'h00);
        for (int c = 0; c < 9; c++) begin
            clr();
            function_enable_setting = 3'h1;
            first_residual_delay = 13'h000C;
            delay_curve_select = ef_trip_pkg::curve_e'(c);
            io_mag = 11'h00B;
            fire(c == 0 ? 12 : 5, 3'h1);
        end
        clr();
        function_enable_setting = 3'h2;
        block_input_option = 3'h2;
        block_input = 1'b1;
        io_mag = 11'h03C;
        cyc(40);
        check(8'({level_pickup, relay_out}), 8'h20);
        block_input = 1'b0;
        wt(3, 4, n);
        check(8'(last_trip), 8'h02);
        io_mag = 11'h030;
        cyc(3);
        check(8'(level_pickup), 8'h02);
        io_mag = 11'h02F;
        cyc(2);
        check(8'(level_pickup), 8'h00);
        clr();
        function_enable_setting = 3'h4;
        io_mag = 11'h0C9;
        fire(6, 3'h3);
        check(8'(osc_trigger), 8'h00);
        io_mag = 11'h0BE;
        cyc(3);
        check(8'(level_pickup), 8'h04);
        io_mag = 11'h0BD;
        cyc(2);
        check(8'(level_pickup), 8'h00);
        clr();
        io_mag = 11'h3E7;
        cyc(60);
        check(8'({trip_led, level_pickup, relay_out}), 8'h00);
        check(8'(osc_trigger), 8'h00);
        check(8'(last_trip), 8'h03);
        remote_trip_input = 1'b1;
        cyc(5);
        check(8'(relay_out), 8'h00);
        remote_trip_function = 1'b1;
        cyc(2);
        check(8'({trip_led, last_trip, relay_out}), 8'hC8);
        supervised_trip_relay = 2'h1;
        cyc(2);
        check(8'(relay_out), 8'h02);
        supervised_trip_relay = 2'h3;
        remote_trip_function = 1'b0;
        breaker_failure_function = 1'b1;
        for (int k = 0; k < 3; k++) begin
            clr();
            function_enable_setting = 3'h1;
            stuck = (k != 0);
            // Exactly 5 percent does not exceed the failure level
            load = (k == 1) ? 13'h0005 : 13'h0064;
            io_mag = 11'h00B;
            fire(5, 3'h1);
            if (k < 2) begin
                cyc(40);
                check(8'(relay_out[0]), 8'h00);
            end else begin
                wt(0, 40, n);
                check(8'(n >= 16 && n <= 28), 8'h01);
                check(8'({last_trip, relay_out}), 8'h59);
            end
        end
        test_done();
    end
endmodule : tb_earth_fault_trip_logic
